/* hdl/crbcc_regs.vh */
// Purpose: Constants for the core reset, boot and clock control block
// Assumes: Included by crbcc_top.v only
// Notes:   Offsets are register-port addresses, 4 bits wide
`ifndef CRBCC_REGS_VH
`define CRBCC_REGS_VH

// Register port addresses
`define CRBCC_ADDR_SYSCTL    4'h0
`define CRBCC_ADDR_WDCTL     4'h1
`define CRBCC_ADDR_CLKCTL    4'h2
`define CRBCC_ADDR_STACKTOP  4'h3
`define CRBCC_ADDR_STATUS    4'h4

// System control fields
`define CRBCC_SC_LOCK_BIT    0
`define CRBCC_SC_LOADER_BIT  1
// Watchdog control fields
`define CRBCC_WD_POR_BIT     7
`define CRBCC_WD_WDRST_BIT   2
`define CRBCC_WD_IRQEN_BIT   0
`define CRBCC_WD_RSTEN_BIT   1
// Clock control fields
`define CRBCC_CK_TIMER_MODE_FIELD_LSB    0
`define CRBCC_CK_PMM_LSB     1

// Reset and boot values
`define CRBCC_STACK_TOP      4'h0_f
`define CRBCC_BOOT_VECTOR    16'h8000
`define CRBCC_APP_VECTOR     16'h0000
`define CRBCC_ROM_WORDS      16'h1000
`define CRBCC_PWD_FIRST      16'h0010
`define CRBCC_PWD_LAST       16'h001f
`define CRBCC_PWD_ALL_ONES   16'hffff
`define CRBCC_PWD_ALL_ZEROS  16'h0000

// Timing: instruction clock 1 MHz from 200 MHz, osc start-up time in ns
`define CRBCC_REF_MHZ        200
`define CRBCC_ICLK_MHZ       1
`define CRBCC_ICLK_DIV       (`CRBCC_REF_MHZ / `CRBCC_ICLK_MHZ)
`define CRBCC_ICLK_HALF      (`CRBCC_ICLK_DIV / 2)
`define CRBCC_TSU_OSC_NS     100000
`define CRBCC_TSU_OSC_CYC    ((`CRBCC_TSU_OSC_NS * `CRBCC_REF_MHZ + 999) / 1000)

`endif

/* hdl/crbcc_top.v */
// Purpose: Reset sources, boot vector, password lock, clock gating, stack
// Assumes: All inputs synchronous to ref_clk; loader firmware is external
// Notes:   Register port: read data valid in the cycle after read strobe
//
// Notes on behaviour
// (RQ1) Sixteen stack entries, sixteen bits each
// (RQ2) Stack index starts at top, 0Fh
// (RQ3) Push: bump index, then write entry
// (RQ4) Pop: read entry, then drop index
// (RQ5) Utility ROM: 4k words from 8000h
// (RQ6) Every reset fetches from ROM first
// (RQ7) Password is words 0010h to 001Fh
// (RQ8) Defined password keeps readout lock set
// (RQ9) Readout lock resets to one
// (RQ10) Mass erase leaves password all ones
// (RQ11) JTAG loader request during reset enters loader
// (RQ12) 2-wire program request, lock needs password
// (RQ13) Loader operations issued by host
// (RQ14) Internal 1 MHz instruction clock
// (RQ15) Analog clock independent, drives timers
// (RQ16) Interrupt or POR enables; stop disables
// (RQ17) Brown-out stops clock; restart after start-up
// (RQ18) Analog clock on for watchdog, timer, protector
// (RQ19) Reset halts execution, clock keeps running
// (RQ20) POR sets power-on flag, boots 8000h
// (RQ21) Watchdog reset sets flag, boots 8000h
// (RQ22) External low pin resets; resume on release
// (RQ23) Stack index wraps modulo sixteen
//
// Local design decisions: the placing of the registers and the plain strobed port.
`include "crbcc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module crbcc_top #(
  parameter TSU_CYC = `CRBCC_TSU_OSC_CYC
) (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        port0_pin2_n,
  input  wire        watchdog_timeout,
  input  wire        brownout_low,
  input  wire        sys_irq,
  input  wire        core_stop,
  input  wire        jtag_loader_set,
  input  wire        twowire_prog_req,
  input  wire        password_match,
  input  wire        loader_exit,
  input  wire        mass_erase,
  input  wire        pwd_valid,
  input  wire [15:0] pwd_addr,
  input  wire [15:0] pwd_word,
  input  wire        stack_push,
  input  wire        stack_pop,
  input  wire [15:0] stack_wdata,
  output reg  [15:0] stack_rdata,
  output reg  [3:0]  stack_index,
  output reg         core_reset,
  output reg  [15:0] fetch_vector,
  output reg         readout_lock_bit,
  output reg         loader_request_bit,
  output reg         loader_active,
  output reg         pwd_force_ones,
  output reg         instruction_clock,
  output reg         iclk_enable,
  output reg         analog_clock_en
);

  // Stack storage
  reg [15:0] stack_mem [0:15]; // RQ1

  // Control registers
  reg        por_flag_reg;
  reg        wd_reset_flag_reg;
  reg        watchdog_irq_enable;
  reg        watchdog_reset_enable;
  reg        timer_mode_field;
  reg [1:0]  protector_mode_field;
  reg        pwd_any_one_reg;
  reg        pwd_any_zero_reg;
  reg        pwd_scan_done_reg;
  reg        ext_rst_seen_reg;
  reg [7:0]  iclk_cnt_reg;
  reg [31:0] tsu_cnt_reg;
  reg        brownout_wait_reg;

  // Helpers
  function [3:0] idx_step;
    input [3:0] idx;
    input       up;
    begin
      idx_step = up ? idx + 4'h1 : idx - 4'h1; // RQ23
    end
  endfunction

  function in_pwd;
    input [15:0] a;
    begin
      in_pwd = (a >= `CRBCC_PWD_FIRST) && (a <= `CRBCC_PWD_LAST); // RQ7
    end
  endfunction

  wire any_reset = ~port0_pin2_n | watchdog_timeout; // RQ22
  wire wr_sc = reg_wr && (reg_addr == `CRBCC_ADDR_SYSCTL);
  wire wr_wd = reg_wr && (reg_addr == `CRBCC_ADDR_WDCTL);
  wire wr_ck = reg_wr && (reg_addr == `CRBCC_ADDR_CLKCTL);
  // Password defined: not all zeros and not all ones
  wire pwd_defined = pwd_any_one_reg & pwd_any_zero_reg; // RQ8
  wire pwd_last = pwd_valid && (pwd_addr == `CRBCC_PWD_LAST);

  // Stack: push bumps index then writes; pop reads then drops
  always @(posedge ref_clk)
  begin
    if (stack_push && !core_reset)
      stack_mem[idx_step(stack_index, 1'b1)] <= stack_wdata; // RQ3
  end

  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stack_index <= `CRBCC_STACK_TOP; // RQ2
      stack_rdata <= 16'h0000;
    end
    else if (core_reset)
      stack_index <= `CRBCC_STACK_TOP; // RQ2
    else if (stack_push)
      stack_index <= idx_step(stack_index, 1'b1); // RQ3
    else if (stack_pop)
    begin
      stack_rdata <= stack_mem[stack_index]; // RQ4
      stack_index <= idx_step(stack_index, 1'b0); // RQ4
    end
  end

  // Reset state, boot vector and reset cause flags
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      core_reset        <= 1'b1; // RQ19
      fetch_vector      <= `CRBCC_BOOT_VECTOR; // RQ5 RQ20
      por_flag_reg      <= 1'b1; // RQ20
      wd_reset_flag_reg <= 1'b0;
      ext_rst_seen_reg  <= 1'b0;
    end
    else
    begin
      // Held in reset while a source is active; one cycle after POR too
      core_reset <= any_reset | loader_exit; // RQ19
      if (any_reset | loader_exit)
        fetch_vector <= `CRBCC_BOOT_VECTOR; // RQ6
      ext_rst_seen_reg <= ~port0_pin2_n; // RQ22
      // Hardware set wins over a software clear
      if (watchdog_timeout)
        wd_reset_flag_reg <= 1'b1; // RQ21
      else if (wr_wd)
        wd_reset_flag_reg <= reg_wdata[`CRBCC_WD_WDRST_BIT];
      if (wr_wd)
        por_flag_reg <= reg_wdata[`CRBCC_WD_POR_BIT];
    end
  end

  // Password scan and readout lock
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      readout_lock_bit  <= 1'b1; // RQ9
      pwd_any_one_reg   <= 1'b0;
      pwd_any_zero_reg  <= 1'b0;
      pwd_scan_done_reg <= 1'b0;
      pwd_force_ones    <= 1'b0;
    end
    else
    begin
      pwd_force_ones <= mass_erase; // RQ10
      if (mass_erase)
      begin
        pwd_any_one_reg   <= 1'b1; // RQ10
        pwd_any_zero_reg  <= 1'b0;
        pwd_scan_done_reg <= 1'b1;
      end
      else if (pwd_valid && in_pwd(pwd_addr))
      begin
        if (pwd_addr == `CRBCC_PWD_FIRST)
        begin
          pwd_any_one_reg  <= (pwd_word != `CRBCC_PWD_ALL_ZEROS);
          pwd_any_zero_reg <= (pwd_word != `CRBCC_PWD_ALL_ONES);
        end
        else
        begin
          pwd_any_one_reg  <= pwd_any_one_reg |
                              (pwd_word != `CRBCC_PWD_ALL_ZEROS);
          pwd_any_zero_reg <= pwd_any_zero_reg |
                              (pwd_word != `CRBCC_PWD_ALL_ONES);
        end
        pwd_scan_done_reg <= pwd_last;
      end
      // Lock may only drop when no completed scan found a defined password or it matched
      if (password_match)
        readout_lock_bit <= 1'b0; // RQ12
      else if (pwd_scan_done_reg && pwd_defined)
        readout_lock_bit <= 1'b1; // RQ8
      else if (wr_sc && !(pwd_scan_done_reg && pwd_defined))
        readout_lock_bit <= reg_wdata[`CRBCC_SC_LOCK_BIT]; // RQ9
    end
  end

  // Loader entry and exit
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loader_request_bit <= 1'b0;
      loader_active      <= 1'b0;
    end
    else
    begin
      if (jtag_loader_set && core_reset)
        loader_request_bit <= 1'b1; // RQ11
      else if (loader_exit || (wr_sc && !reg_wdata[`CRBCC_SC_LOADER_BIT]))
        loader_request_bit <= 1'b0; // RQ11
      if (loader_exit)
        loader_active <= 1'b0; // RQ12
      else if (loader_request_bit && !core_reset)
        loader_active <= 1'b1; // RQ11
      else if (twowire_prog_req && (!readout_lock_bit || password_match))
        loader_active <= 1'b1; // RQ12 RQ13
    end
  end

  // Instruction clock gate and brown-out start-up wait
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      iclk_enable       <= 1'b1; // RQ16
      brownout_wait_reg <= 1'b0;
      tsu_cnt_reg       <= 32'h0000_0000;
    end
    else if (brownout_low)
    begin
      iclk_enable       <= 1'b0; // RQ17
      brownout_wait_reg <= 1'b1;
      tsu_cnt_reg       <= 32'h0000_0000;
    end
    else if (brownout_wait_reg)
    begin
      // Counting start-up time; the oscillator is not trusted before
      if (tsu_cnt_reg >= TSU_CYC - 1)
      begin
        iclk_enable       <= 1'b1; // RQ17
        brownout_wait_reg <= 1'b0;
      end
      else
        tsu_cnt_reg <= tsu_cnt_reg + 32'h0000_0001;
    end
    else if (sys_irq || any_reset)
      iclk_enable <= 1'b1; // RQ16 RQ19
    else if (core_stop && !core_reset)
      iclk_enable <= 1'b0; // RQ16
  end

  // 1 MHz instruction clock by division; runs through reset
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      iclk_cnt_reg      <= 8'h00;
      instruction_clock <= 1'b0;
    end
    else if (!iclk_enable)
      instruction_clock <= 1'b0;
    else if (iclk_cnt_reg == `CRBCC_ICLK_HALF - 1)
    begin
      iclk_cnt_reg      <= 8'h00;
      instruction_clock <= ~instruction_clock; // RQ14
    end
    else
      iclk_cnt_reg <= iclk_cnt_reg + 8'h01;
  end

  // Analog clock request, separate from instruction clock gate
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      analog_clock_en       <= 1'b0;
      watchdog_irq_enable   <= 1'b0;
      watchdog_reset_enable <= 1'b0;
      timer_mode_field      <= 1'b0;
      protector_mode_field  <= 2'b00;
    end
    else
    begin
      if (wr_wd)
      begin
        watchdog_irq_enable   <= reg_wdata[`CRBCC_WD_IRQEN_BIT];
        watchdog_reset_enable <= reg_wdata[`CRBCC_WD_RSTEN_BIT];
      end
      if (wr_ck)
      begin
        timer_mode_field     <= reg_wdata[`CRBCC_CK_TIMER_MODE_FIELD_LSB];
        protector_mode_field <= reg_wdata[`CRBCC_CK_PMM_LSB+1:
                                          `CRBCC_CK_PMM_LSB];
      end
      analog_clock_en <= watchdog_irq_enable | watchdog_reset_enable |
                         timer_mode_field | (|protector_mode_field); // RQ15 RQ18
    end
  end

  // Register read port, data one cycle after strobe
  always @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `CRBCC_ADDR_SYSCTL:
          reg_rdata <= {14'h0000, loader_request_bit, readout_lock_bit};
        `CRBCC_ADDR_WDCTL:
          reg_rdata <= {8'h00, por_flag_reg, 4'h0, wd_reset_flag_reg,
                        watchdog_reset_enable, watchdog_irq_enable};
        `CRBCC_ADDR_CLKCTL:
          reg_rdata <= {13'h0000, protector_mode_field, timer_mode_field};
        `CRBCC_ADDR_STACKTOP:
          reg_rdata <= {12'h000, stack_index};
        `CRBCC_ADDR_STATUS:
          reg_rdata <= {11'h000, pwd_defined, loader_active,
                        analog_clock_en, iclk_enable, core_reset};
        default:
          reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

endmodule // crbcc_top

`default_nettype wire

/* dv/crbcc_checker.sv */
// Purpose: Port assertions for crbcc_top
// Assumes: Bench runs TSU_CYC at 8 or more
// Notes:   Bound by name onto every crbcc_top
`timescale 1ns/1ps
`default_nettype none
module crbcc_checker (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        port0_pin2_n,
  input wire logic        watchdog_timeout,
  input wire logic        brownout_low,
  input wire logic        sys_irq,
  input wire logic        core_stop,
  input wire logic        stack_push,
  input wire logic        stack_pop,
  input wire logic [3:0]  stack_index,
  input wire logic        core_reset,
  input wire logic [15:0] fetch_vector,
  input wire logic        readout_lock_bit,
  input wire logic        iclk_enable
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Supply back above threshold
  sequence s_bo_end;
    $fell(brownout_low);
  endsequence
  property p_push;
    stack_push && !core_reset |=> stack_index == $past(stack_index) + 4'h1;
  endproperty
  a_push: assert property (p_push) else $error("push index");
  property p_pop;
    stack_pop && !stack_push && !core_reset |=>
      stack_index == $past(stack_index) - 4'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("pop index");
  property p_vec;
    fetch_vector == 16'h8000;
  endproperty
  a_vec: assert property (p_vec) else $error("boot vector");
  property p_ext;
    !port0_pin2_n |-> ##[1:2] core_reset;
  endproperty
  a_ext: assert property (p_ext) else $error("pin reset");
  property p_wdt;
    watchdog_timeout |-> ##[1:2] core_reset;
  endproperty
  a_wdt: assert property (p_wdt) else $error("wdt reset");
  // Start-up wait must not be skipped
  property p_bo;
    s_bo_end |-> !iclk_enable [*8];
  endproperty
  a_bo: assert property (p_bo) else $error("early restart");
  property p_stop;
    core_stop && !sys_irq && !brownout_low |=> !iclk_enable;
  endproperty
  a_stop: assert property (p_stop) else $error("stop clock");
  property p_lock;
    $rose(reset_n) |-> readout_lock_bit;
  endproperty
  a_lock: assert property (p_lock) else $error("lock reset");
endmodule // crbcc_checker
bind crbcc_top crbcc_checker chk_u (.*);
`default_nettype wire

/* dv/crbcc_host.sv */
// Purpose: Programming host on the JTAG and 2-wire side
// Assumes: One command at a time, one cycle each
// Notes:   Kind 3 jtag, 2 program, 1 match, 0 exit
`timescale 1ns/1ps
`default_nettype none
module crbcc_host (
  input  wire logic ref_clk,
  output var  logic jtag_loader_set,
  output var  logic twowire_prog_req,
  output var  logic password_match,
  output var  logic loader_exit
);
  initial
  begin
    {jtag_loader_set, twowire_prog_req, password_match, loader_exit} = 4'h0;
  end
  // Single-cycle command strobe
  task automatic send(input int kind);
    @(posedge ref_clk);
    {jtag_loader_set, twowire_prog_req, password_match, loader_exit}
      <= 4'h1 << kind;
    @(posedge ref_clk);
    {jtag_loader_set, twowire_prog_req, password_match, loader_exit} <= 4'h0;
  endtask
endmodule // crbcc_host
`default_nettype wire

/* dv/core_reset_boot_clock_control_tb.sv */
// Purpose: Self-checking bench for crbcc_top
// Assumes: Start-up wait shortened to 10 cycles
// Notes:   Every scenario judges its own results
`timescale 1ns/1ps
`default_nettype none
module core_reset_boot_clock_control_tb;
  localparam int TSU = 10;
  logic        ref_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        port0_pin2_n = 1'b1, brownout_low = 1'b0, sys_irq = 1'b0;
  logic        core_stop = 1'b0, mass_erase = 1'b0, pwd_valid = 1'b0;
  logic        stack_push = 1'b0, stack_pop = 1'b0, watchdog_timeout = 1'b0;
  logic [3:0]  reg_addr = 4'h0, stack_index;
  logic [15:0] reg_wdata = 16'h0000, pwd_addr = 16'h0000;
  logic [15:0] pwd_word = 16'h0000, stack_wdata = 16'h0000;
  logic [15:0] reg_rdata, stack_rdata, fetch_vector;
  logic        jtag_loader_set, twowire_prog_req, password_match, loader_exit;
  logic        core_reset, readout_lock_bit, loader_request_bit, loader_active;
  logic        pwd_force_ones, instruction_clock, iclk_enable, analog_clock_en;
  int          err_total = 0, checks_done = 0;
  crbcc_top #(.TSU_CYC(TSU)) dut_u (.*);
  crbcc_host host_u (.*);
  always #2.5 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Register port: one-cycle strobes, read data one cycle later
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic scan(input logic [15:0] a, w);
    @(posedge ref_clk);
    pwd_valid <= 1'b1;
    pwd_addr <= a;
    pwd_word <= w;
    @(posedge ref_clk);
    pwd_valid <= 1'b0;
  endtask
  task automatic t_reset();
    logic [15:0] d;
    chk("index", stack_index, 16'h000f);
    chk("lock", readout_lock_bit, 16'h0001);
    chk("vector", fetch_vector, 16'h8000);
    rd(4'h1, d);
    chk("por flag", d[7], 16'h0001);
    rd(4'h9, d);
    chk("unmapped", d, 16'h0000);
  endtask
  // Fill all sixteen entries, wrap, then drain back to back
  task automatic t_stack();
    for (int i = 0; i < 16; i++)
    begin
      @(posedge ref_clk);
      stack_push <= 1'b1;
      stack_wdata <= 16'ha5a0 + 16'(i);
    end
    @(posedge ref_clk);
    stack_push <= 1'b0;
    stack_pop <= 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge ref_clk);
      stack_pop <= (i != 0);
      #1 chk("pop", stack_rdata, 16'ha5a0 + 16'(i));
    end
    chk("wrap", stack_index, 16'h000f);
  endtask
  task automatic t_pwd();
    scan(16'h0020, 16'h3c5a);
    wr(4'h0, 16'h0000);
    chk("no pwd", readout_lock_bit, 16'h0000);
    wr(4'h0, 16'h0001);
    // Whole password area, so the scan completes
    for (int i = 0; i < 16; i++)
    begin
      scan(16'h0010 + 16'(i), 16'h3c5a);
    end
    wr(4'h0, 16'h0000);
    chk("lock kept", readout_lock_bit, 16'h0001);
    host_u.send(1);
    #1 chk("unlock", readout_lock_bit, 16'h0000);
    @(posedge ref_clk);
    mass_erase <= 1'b1;
    @(posedge ref_clk);
    mass_erase <= 1'b0;
    #1 chk("erase", pwd_force_ones, 16'h0001);
  endtask
  task automatic t_loader();
    logic [15:0] d;
    int          n;
    @(posedge ref_clk);
    port0_pin2_n <= 1'b0;
    cyc(3);
    chk("pin rst", core_reset, 16'h0001);
    host_u.send(3);
    #1 chk("ldr req", loader_request_bit, 16'h0001);
    count_tog(n);
    chk("toggles", 16'(n), 16'h0004);
    @(posedge ref_clk);
    port0_pin2_n <= 1'b1;
    cyc(4);
    chk("release", core_reset, 16'h0000);
    wr(4'h0, 16'h0000);
    chk("ldr clr", loader_request_bit, 16'h0000);
    host_u.send(0);
    cyc(2);
    chk("ldr off", loader_active, 16'h0000);
    host_u.send(2);
    cyc(2);
    chk("ldr on", loader_active, 16'h0001);
    host_u.send(0);
    #1;
    chk("exit rst", core_reset, 16'h0001);
    cyc(4);
    @(posedge ref_clk);
    stack_push <= 1'b1;
    watchdog_timeout <= 1'b0;
    @(posedge ref_clk);
    stack_push <= 1'b0;
    watchdog_timeout <= 1'b1;
    @(posedge ref_clk);
    watchdog_timeout <= 1'b0;
    #1;
    chk("wdt rst", core_reset, 16'h0001);
    cyc(4);
    chk("idx rst", stack_index, 16'h000f);
    rd(4'h1, d);
    chk("wdt flag", d[2], 16'h0001);
  endtask
  // Toggles of the instruction clock over 400 cycles
  task automatic count_tog(output int n);
    logic prev;
    n = 0;
    prev = instruction_clock;
    repeat (400)
    begin
      @(posedge ref_clk);
      #1;
      if (instruction_clock !== prev)
        n++;
      prev = instruction_clock;
    end
  endtask
  task automatic t_clock();
    logic [3:0] a;
    @(posedge ref_clk);
    brownout_low <= 1'b1;
    cyc(5);
    chk("bo off", iclk_enable, 16'h0000);
    brownout_low <= 1'b0;
    cyc(TSU - 3);
    chk("bo wait", iclk_enable, 16'h0000);
    cyc(6);
    chk("bo on", iclk_enable, 16'h0001);
    @(posedge ref_clk);
    core_stop <= 1'b1;
    @(posedge ref_clk);
    core_stop <= 1'b0;
    cyc(1);
    chk("stop", iclk_enable, 16'h0000);
    sys_irq <= 1'b1;
    @(posedge ref_clk);
    sys_irq <= 1'b0;
    cyc(1);
    chk("irq", iclk_enable, 16'h0001);
    for (int i = 0; i < 5; i++)
    begin
      a = (i < 3) ? 4'h2 : 4'h1;
      wr(a, 16'h0001 << ((i < 3) ? i : i - 3));
      cyc(3);
      chk("aclk on", analog_clock_en, 16'h0001);
      wr(a, 16'h0000);
      cyc(3);
      chk("aclk off", analog_clock_en, 16'h0000);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    cyc(2);
    t_reset();
    t_stack();
    t_pwd();
    t_loader();
    t_clock();
    test_done();
  end
  // Hang guard, some thirty times the expected run
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    test_done();
  end
endmodule // core_reset_boot_clock_control_tb
`default_nettype wire
